/* rtl/msr_readback.sv */
// msr_readback: per-axis event causes, pulse counter, monitors and shared circular step counter
// assumes apb master on REF_CLK_IN and event strobes synchronous to the same clock
//
// Operation
// - an event sets its own cause bit, other cause bits kept.
// - hold mode set: read does not clear; error-cause write clears causes.
// - bits 0..7: stop, next start, prereg free, cmp5 prereg, accel/decel edges.
// - bits 8..12 flag comparators one to five.
// - bit 13 count clear, 14 latch input, 15 origin latch.
// - bit 16 slowdown on, 17/18 jog changes, 19 sync start on.
// - start loads pulse counter with abs target; each pulse decrements, stopping at zero.
// - pulse counter read-only, returns 0 to 2,147,483,647.
// - speed monitor bits 0..15 give present speed, zero when stopped.
// - speed monitor bits 16..19 give index pulse tally.
// - bits 20..22 give idle tally; upper bits zero.
// - ramp-down readback 24 bits, upper eight zero.
// - circular preset registers only on X, Y, Z.
// - host writes step count; ramp-down used only when nonzero.
// - circular start loads counter from X preset; each step decrements.
// - circular counter saturates at zero.
// - counter holds final value until next circular start.
// - one circular counter shared, same value from every axis.
// - circular counter is 32 bits wide.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module msr_readback
   import msr_pkg::*;
#(
   parameter int N_AXES = NUM_AXES
) (
   input wire logic REF_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire msr_pkg::msr_axis_s [N_AXES-1:0] AXIS_IN,
   input wire msr_pkg::msr_circ_s CIRC_IN,
   output msr_pkg::msr_apb_rsp_s APB_RSP_OUT,
   output logic [N_AXES-1:0] EVENT_IRQ_OUT,
   output logic [N_AXES-1:0] RAMP_DOWN_ENABLE_OUT
);
   import msr_pkg::*;

   typedef struct packed {
      msr_evt_t [N_AXES-1:0] cause;
      logic [N_AXES-1:0][31:0] env_five;
      logic [N_AXES-1:0][31:0] remain;
      logic [N_AXES-1:0] jog_plus_d;
      logic [N_AXES-1:0] jog_minus_d;
      logic [N_AXES-1:0] slowdown_d;
      logic [N_AXES-1:0] sync_start_d;
      logic [NUM_CIRC_AXES-1:0][31:0] circ_preset;
      logic [31:0] circ_counter;
      msr_apb_rsp_s rsp;
      logic [N_AXES-1:0] irq;
      logic [N_AXES-1:0] ramp_en;
   } msr_state_s;

   msr_state_s state_r;
   msr_state_s state_nxt;

   logic apb_setup;
   logic [AXIS_BITS-1:0] sel_axis;
   logic [5:0] sel_ofs;
   msr_evt_t [N_AXES-1:0] raw_evt;

   assign apb_setup = PSEL_IN && !PENABLE_IN;
   assign sel_axis = PADDR_IN[AXIS_LSB +: AXIS_BITS];
   assign sel_ofs = PADDR_IN[AXIS_LSB-1:0];

   // per-axis event vector in cause-bit order
   genvar g;
   generate
      for (g = 0; g < N_AXES; g++) begin : g_evt
         always_comb begin
            raw_evt[g] = '0;
            raw_evt[g][EV_AUTO_STOP +: 8] = AXIS_IN[g].motion_events;
            raw_evt[g][EV_CMP_ONE +: 5] = AXIS_IN[g].comparator_hits;
            raw_evt[g][EV_COUNT_CLEARED] = AXIS_IN[g].count_cleared;
            raw_evt[g][EV_COUNT_CLEARED+1] = AXIS_IN[g].count_latched;
            raw_evt[g][EV_COUNT_CLEARED+2] = AXIS_IN[g].origin_latched;
            raw_evt[g][EV_SLOWDOWN_ON] = AXIS_IN[g].slowdown_input && !state_r.slowdown_d[g];
            raw_evt[g][EV_JOG_PLUS] = AXIS_IN[g].jog_plus_input ^ state_r.jog_plus_d[g];
            raw_evt[g][EV_JOG_MINUS] = AXIS_IN[g].jog_minus_input ^ state_r.jog_minus_d[g];
            raw_evt[g][EV_SYNC_START] = AXIS_IN[g].sync_start_input && !state_r.sync_start_d[g];
         end
      end
   endgenerate

   function automatic logic [31:0] abs_clip(input logic [31:0] v);
      logic [31:0] m;
      m = v[31] ? 32'(-v) : v;
      abs_clip = (m > PULSE_MAX) ? PULSE_MAX : m;
   endfunction

   always_comb begin
      logic rd;
      logic wr;
      logic [31:0] rdata;
      logic err;
      msr_evt_t clr;
      state_nxt = state_r;
      rd = apb_setup && !PWRITE_IN;
      wr = apb_setup && PWRITE_IN;
      rdata = ZERO_WORD;
      err = 1'b0;
      state_nxt.rsp.pready = apb_setup;
      for (int a = 0; a < N_AXES; a++) begin
         state_nxt.jog_plus_d[a] = AXIS_IN[a].jog_plus_input;
         state_nxt.jog_minus_d[a] = AXIS_IN[a].jog_minus_input;
         state_nxt.slowdown_d[a] = AXIS_IN[a].slowdown_input;
         state_nxt.sync_start_d[a] = AXIS_IN[a].sync_start_input;
         // remaining pulse counter
         if (AXIS_IN[a].op_start) begin
            state_nxt.remain[a] = abs_clip(AXIS_IN[a].target_move_working);
         end else if (AXIS_IN[a].pulse_out && state_r.remain[a] != ZERO_WORD) begin
            state_nxt.remain[a] = state_r.remain[a] - 32'h0000_0001;
         end
         // cause clearing: read in normal mode, error-cause write in hold mode
         clr = '0;
         if (sel_axis == AXIS_BITS'(a)) begin
            if (rd && sel_ofs == OFS_EVENT_CAUSE && !state_r.env_five[a][HOLD_MODE_BIT]) begin
               clr = '1;
            end
            if (wr && sel_ofs == OFS_ERROR_CAUSE && state_r.env_five[a][HOLD_MODE_BIT]) begin
               clr = '1;
            end
            if (wr && sel_ofs == OFS_ENV_FIVE) begin
               state_nxt.env_five[a] = PWDATA_IN;
            end
         end
         // set wins over clear in the same cycle
         state_nxt.cause[a] = (state_r.cause[a] & ~clr) | raw_evt[a];
         state_nxt.irq[a] = |state_nxt.cause[a];
      end
      // preset writes, X Y Z only
      for (int c = 0; c < NUM_CIRC_AXES; c++) begin
         if (wr && sel_ofs == OFS_CIRC_PRESET && sel_axis == AXIS_BITS'(c)) begin
            state_nxt.circ_preset[c] = PWDATA_IN;
         end
         state_nxt.ramp_en[c] = state_nxt.circ_preset[c] != ZERO_WORD;
      end
      for (int u = NUM_CIRC_AXES; u < N_AXES; u++) begin
         state_nxt.ramp_en[u] = 1'b0;
      end
      // shared circular step counter
      if (CIRC_IN.circ_start) begin
         state_nxt.circ_counter = state_r.circ_preset[0];
      end else if (CIRC_IN.circ_step && state_r.circ_counter != ZERO_WORD) begin
         state_nxt.circ_counter = state_r.circ_counter - 32'h0000_0001;
      end
      // otherwise held until the next start
      // compare as int: N_AXES does not fit the 2-bit axis field when all four axes exist
      if (int'(sel_axis) < N_AXES) begin
         case (sel_ofs)
            OFS_EVENT_CAUSE: rdata = 32'(state_r.cause[sel_axis]);
            OFS_REMAIN_PULSE: rdata = state_r.remain[sel_axis];
            OFS_SPEED_MON: begin
               rdata = ZERO_WORD;
               if (AXIS_IN[sel_axis].running) begin
                  rdata[15:0] = AXIS_IN[sel_axis].present_speed_step;
               end
               rdata[SPD_IDX_LSB +: 4] = AXIS_IN[sel_axis].index_pulse_tally;
               rdata[SPD_IDLE_LSB +: 3] = AXIS_IN[sel_axis].idle_pulse_tally;
            end
            OFS_RAMP_DOWN: rdata = {8'h00, AXIS_IN[sel_axis].ramp_down_point};
            OFS_CIRC_PRESET: begin
               if (sel_axis < AXIS_BITS'(NUM_CIRC_AXES)) begin
                  rdata = state_r.circ_preset[sel_axis];
               end else begin
                  err = 1'b1;
               end
            end
            OFS_CIRC_COUNTER: rdata = state_r.circ_counter;
            OFS_ERROR_CAUSE: rdata = ZERO_WORD;
            OFS_ENV_FIVE: rdata = state_r.env_five[sel_axis];
            default: err = 1'b1;
         endcase
      end else begin
         err = 1'b1;
      end
      if (apb_setup) begin
         state_nxt.rsp.prdata = PWRITE_IN ? ZERO_WORD : rdata;
         state_nxt.rsp.pslverr = err;
      end else begin
         state_nxt.rsp.pslverr = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign APB_RSP_OUT = state_r.rsp;
   assign EVENT_IRQ_OUT = state_r.irq;
   assign RAMP_DOWN_ENABLE_OUT = state_r.ramp_en;
endmodule // msr_readback

/* rtl/msr_pkg.sv */
// msr_pkg: constants, field layouts and carriers for the motion status readback block
// assumes an apb slave with 32-bit data and word-aligned registers
package msr_pkg;
   localparam int NUM_AXES = 4;
   localparam int NUM_CIRC_AXES = 3;
   localparam int AXIS_BITS = 2;
   localparam int EVT_BITS = 20;
   // per-axis register window: axis index in address bits [7:6]
   localparam int AXIS_LSB = 6;
   localparam logic [5:0] OFS_EVENT_CAUSE = 6'h00;
   localparam logic [5:0] OFS_REMAIN_PULSE = 6'h04;
   localparam logic [5:0] OFS_SPEED_MON = 6'h08;
   localparam logic [5:0] OFS_RAMP_DOWN = 6'h0c;
   localparam logic [5:0] OFS_CIRC_PRESET = 6'h10;
   localparam logic [5:0] OFS_CIRC_COUNTER = 6'h14;
   localparam logic [5:0] OFS_ERROR_CAUSE = 6'h18;
   localparam logic [5:0] OFS_ENV_FIVE = 6'h1c;
   localparam int HOLD_MODE_BIT = 24;
   localparam int SPD_IDX_LSB = 16;
   localparam int SPD_IDLE_LSB = 20;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] CIRC_RESET = 32'h0000_0000;
   localparam logic [31:0] PULSE_MAX = 32'h7fff_ffff;

   // event bit positions
   localparam int EV_AUTO_STOP = 0;
   localparam int EV_CMP_ONE = 8;
   localparam int EV_COUNT_CLEARED = 13;
   localparam int EV_SLOWDOWN_ON = 16;
   localparam int EV_JOG_PLUS = 17;
   localparam int EV_JOG_MINUS = 18;
   localparam int EV_SYNC_START = 19;

   typedef logic [EVT_BITS-1:0] msr_evt_t;

   // per-axis inputs from the pulse generator core
   typedef struct packed {
      logic [7:0] motion_events;   // bits 0..7 of the cause map
      logic [4:0] comparator_hits; // comparators 1..5
      logic count_cleared;
      logic count_latched;
      logic origin_latched;
      logic slowdown_input;
      logic jog_plus_input;
      logic jog_minus_input;
      logic sync_start_input;
      logic op_start;
      logic [31:0] target_move_working;
      logic pulse_out;
      logic running;
      logic [15:0] present_speed_step;
      logic [3:0] index_pulse_tally;
      logic [2:0] idle_pulse_tally;
      logic [23:0] ramp_down_point;
   } msr_axis_s;

   // shared circular interpolation stimulus
   typedef struct packed {
      logic circ_start;
      logic circ_step;
   } msr_circ_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } msr_apb_rsp_s;
endpackage

/* tb/msr_readback_asserts.sv */
// msr_readback_asserts: apb timing, error, interrupt and field relations of msr_readback
// assumes msr_pkg compiled first; bound onto every msr_readback instance
`timescale 1ns/1ps
module msr_readback_asserts
   import msr_pkg::*;
#(
   parameter int N_AXES = NUM_AXES
) (
   input wire logic REF_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire msr_pkg::msr_axis_s [N_AXES-1:0] AXIS_IN,
   input wire msr_pkg::msr_circ_s CIRC_IN,
   input wire msr_pkg::msr_apb_rsp_s APB_RSP_OUT,
   input wire logic [N_AXES-1:0] EVENT_IRQ_OUT,
   input wire logic [N_AXES-1:0] RAMP_DOWN_ENABLE_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   wire setup = PSEL_IN && !PENABLE_IN;
   wire rd_ok = APB_RSP_OUT.pready && !PWRITE_IN;
   a_answer_next: assert property (setup |=> APB_RSP_OUT.pready && $stable(PADDR_IN))
      else $error("no answer after setup");
   a_answer_only: assert property (APB_RSP_OUT.pready |-> PENABLE_IN && $past(setup))
      else $error("answer outside access");
   a_unmapped_err: assert property (setup && PADDR_IN[5] |=> APB_RSP_OUT.pslverr)
      else $error("unmapped offset accepted");
   a_u_preset_err: assert property (setup && PADDR_IN == {2'd3, OFS_CIRC_PRESET} |=> APB_RSP_OUT.pslverr)
      else $error("u axis preset accepted");
   a_u_no_ramp: assert property (!RAMP_DOWN_ENABLE_OUT[N_AXES-1])
      else $error("u axis ramp enable");
   a_ramp_on: assert property (setup && PWRITE_IN && PADDR_IN == {2'd0, OFS_CIRC_PRESET} && PWDATA_IN != 0
      |-> ##[1:3] RAMP_DOWN_ENABLE_OUT[0]) else $error("ramp enable missing");
   a_event_irq: assert property (AXIS_IN[0].motion_events[0] |-> ##[1:3] EVENT_IRQ_OUT[0])
      else $error("irq missing after event");
   a_pulse_range: assert property (rd_ok && PADDR_IN[5:0] == OFS_REMAIN_PULSE |-> !APB_RSP_OUT.prdata[31])
      else $error("pulse count out of range");
   a_speed_top: assert property (rd_ok && PADDR_IN[5:0] == OFS_SPEED_MON |-> APB_RSP_OUT.prdata[31:23] == 0)
      else $error("speed upper bits set");
   a_ramp_top: assert property (rd_ok && PADDR_IN[5:0] == OFS_RAMP_DOWN |-> APB_RSP_OUT.prdata[31:24] == 0)
      else $error("ramp point upper bits set");
endmodule // msr_readback_asserts
bind msr_readback msr_readback_asserts #(.N_AXES(N_AXES)) u_asserts (.REF_CLK_IN, .SYS_RST_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .AXIS_IN, .CIRC_IN, .APB_RSP_OUT, .EVENT_IRQ_OUT,
   .RAMP_DOWN_ENABLE_OUT);

/* tb/testbench.sv */
// testbench: random and corner stimulus for msr_readback over apb, self-checking
// assumes msr_pkg, msr_readback and the checker are compiled first
`timescale 1ns/1ps
module testbench;
   import msr_pkg::*;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
   logic [7:0] pa = 0;
   logic [31:0] pwd = 0, rd, t;
   logic [3:0] irq, rde;
   msr_axis_s [3:0] ax = '0;
   msr_circ_s ci = '0;
   msr_apb_rsp_s rsp;
   int miscompares = 0, checks_done = 0, k, n;
   always #20 clk = ~clk;
   msr_readback u_dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(pa), .PWDATA_IN(pwd), .AXIS_IN(ax), .CIRC_IN(ci), .APB_RSP_OUT(rsp), .EVENT_IRQ_OUT(irq),
      .RAMP_DOWN_ENABLE_OUT(rde));
   task automatic wrap_up;
      if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input int a, input logic [5:0] o, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      pa <= {a[1:0], o};
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         i++;
      end while (rsp.pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         miscompares++;
         wrap_up();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   // event inputs occupy bits 82..101 of the axis struct
   function automatic int pos(input int b);
      return b < 8 ? 94 + b : b < 13 ? 81 + b : 101 - b;
   endfunction
   function automatic logic [31:0] mag(input logic [31:0] v);
      v = v[31] ? -v : v;
      return v > PULSE_MAX ? PULSE_MAX : v;
   endfunction
   task automatic ev(input int a, input int b);
      @(posedge clk);
      ax[a][pos(b)] <= 1;
      @(posedge clk);
      ax[a][pos(b)] <= 0;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      k = $urandom(32'hb305);
      repeat (6) @(posedge clk);
      rst <= 0;
      for (int b = 0; b < 20; b++) begin
         k = $urandom_range(3);
         ev(k, b);
         chk(irq[k], 1);
         bus(0, k, OFS_EVENT_CAUSE, 0);
         chk(rd, 32'h1 << b);
         bus(0, k, OFS_EVENT_CAUSE, 0);
         chk(rd, 0);
         repeat (2) @(posedge clk);
         chk(irq[k], 0);
      end
      bus(1, 1, OFS_ENV_FIVE, 32'h1 << HOLD_MODE_BIT);
      ev(1, 13);
      ev(1, 8);
      bus(0, 1, OFS_EVENT_CAUSE, 0);
      bus(0, 1, OFS_EVENT_CAUSE, 0);
      chk(rd, 32'h2100);
      bus(1, 1, OFS_ERROR_CAUSE, 0);
      bus(0, 1, OFS_EVENT_CAUSE, 0);
      chk(rd, 0);
      bus(1, 1, OFS_ENV_FIVE, 0);
      for (int i = 0; i < 4; i++) begin
         t = i == 0 ? 32'h8000_0000 : $urandom;
         n = $urandom_range(9, 1);
         @(posedge clk);
         ax[i].target_move_working <= t;
         ax[i].op_start <= 1;
         ax[i].running <= i[0];
         ax[i].present_speed_step <= $urandom;
         ax[i].index_pulse_tally <= $urandom;
         ax[i].idle_pulse_tally <= $urandom;
         ax[i].ramp_down_point <= $urandom;
         @(posedge clk);
         ax[i].op_start <= 0;
         repeat (n) begin
            @(posedge clk);
            ax[i].pulse_out <= 1;
            @(posedge clk);
            ax[i].pulse_out <= 0;
         end
         bus(1, i, OFS_REMAIN_PULSE, 0);
         bus(0, i, OFS_REMAIN_PULSE, 0);
         chk(rd, mag(t) - n);
         bus(0, i, OFS_SPEED_MON, 0);
         chk(rd, {9'h0, ax[i].idle_pulse_tally, ax[i].index_pulse_tally, i[0] ? ax[i].present_speed_step : 16'h0});
         bus(0, i, OFS_RAMP_DOWN, 0);
         chk(rd, {8'h0, ax[i].ramp_down_point});
      end
      t = $urandom_range(200, 50);
      bus(1, 0, OFS_CIRC_PRESET, t);
      bus(1, 3, OFS_CIRC_PRESET, 5);
      chk(err, 1);
      chk(rde, 4'b0001);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         ci.circ_start <= 1;
         @(posedge clk);
         ci.circ_start <= 0;
         repeat (i ? t + 4 : 3) begin
            @(posedge clk);
            ci.circ_step <= 1;
            @(posedge clk);
            ci.circ_step <= 0;
         end
         for (int a = 0; a < 4; a++) begin
            bus(0, a, OFS_CIRC_COUNTER, 0);
            chk(rd, i ? 32'h0 : t - 3);
         end
      end
      bus(1, 0, OFS_CIRC_PRESET, 0);
      bus(0, 2, 6'h20, 0);
      chk({err, rde[0]}, 2'b10);
      wrap_up();
   end
endmodule // testbench
